// ==== logic/status_pkg.sv ====
// Constants for the monitor interrupt status flag block
// Summary of operation
// - Status one bits 0-3 flag supply violations
// - Flags stick; read clears only if subsided
// - Status one bits 4-6 flag temperature violations
// - Status one bit 7 ORs status two
// - Status two bit 0 flags twelve volt
// - CORE_VOLTAGE_CODE mode: bit 0 flags code change
// - Code change flag can raise the alert
// - Bit 1 overheat; clears below hysteresis only
// - Status two bits 2-4 flag slow fans
// - Fan flags suppressed while PWM is off
// - Bit 5 fan four, gated by PWM three
// - Timer mode: bit 5 flags assertion overrun
// - Bits 6-7 flag diode open or short
// - Status two at index 0x42, resets zero
// - Status one at index 0x41, resets zero
package status_pkg;
	localparam int ADDR_WIDTH = 12;
	localparam int INDEX_WIDTH = 8;
	localparam logic [7:0] STATUS1_INDEX = 8'h41;
	localparam logic [7:0] STATUS2_INDEX = 8'h42;
	localparam logic [7:0] CONFIG_INDEX = 8'h7E;
	localparam logic [7:0] MASK_INDEX = 8'h7F;
	localparam logic [7:0] STATUS1_RESET = 8'h00;
	localparam logic [7:0] STATUS2_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam int S1_SUPPLY_LSB = 0;
	localparam int S1_TEMP_LSB = 4;
	localparam int S1_SUMMARY_BIT = 7;
	localparam int S2_TWELVE_VID_BIT = 0;
	localparam int S2_OVERHEAT_BIT = 1;
	localparam int S2_COOLER_LSB = 2;
	localparam int S2_COOLER_FOUR_BIT = 5;
	localparam int S2_DIODE_LSB = 6;
	localparam int CFG_VID_SELECT_BIT = 0;
	localparam int CFG_TIMER_MODE_BIT = 1;
	localparam int CLK_FREQ_MHZ = 10;
	localparam int VID_WINDOW_US = 11;
	localparam int VID_WINDOW_CYCLES = VID_WINDOW_US * CLK_FREQ_MHZ;
	localparam int VID_COUNT_WIDTH = $clog2(VID_WINDOW_CYCLES);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== logic/monitor_interrupt_status_flags.sv ====
// Interrupt status flags with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
module monitor_interrupt_status_flags #(
	parameter int VID_WIDTH = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [status_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [status_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] supply_out_of_limit,
	input wire logic [2:0] temp_out_of_limit,
	input wire logic twelve_volt_out_of_limit,
	input wire logic [VID_WIDTH-1:0] core_voltage_code,
	input wire logic overheat_limit_hit,
	input wire logic overheat_below_hyst,
	input wire logic overheat_timer_over,
	input wire logic [3:0] cooler_slow,
	input wire logic [2:0] pwm_off,
	input wire logic [1:0] diode_fault,
	output logic irq
);

	generate
		if (VID_WIDTH != 6) begin : g_bad_vid
			$error("VID_WIDTH must be 6");
		end
		if (status_pkg::ADDR_WIDTH < 10) begin : g_bad_addr
			$error("Address too narrow for register indices");
		end
		if (status_pkg::S1_SUPPLY_LSB + 4 >
			status_pkg::S1_TEMP_LSB) begin : g_bad_supply
			$error("Supply field overlaps the temperature field");
		end
		if (status_pkg::S1_TEMP_LSB + 3 > 7) begin : g_bad_s1
			$error("Temperature field overlaps the summary bit");
		end
		if (status_pkg::S2_COOLER_FOUR_BIT !=
			status_pkg::S2_COOLER_LSB + 3) begin : g_bad_cooler
			$error("Fan four bit must follow the fan field");
		end
		if (status_pkg::S2_DIODE_LSB + 2 > 8) begin : g_bad_s2
			$error("Diode field outside status two");
		end
		if (status_pkg::CFG_TIMER_MODE_BIT > 7) begin : g_bad_cfg
			$error("Configuration field outside the register");
		end
		if (status_pkg::CFG_VID_SELECT_BIT ==
			status_pkg::CFG_TIMER_MODE_BIT) begin : g_bad_modes
			$error("Mode bits must differ");
		end
		if (status_pkg::VID_WINDOW_CYCLES < 2) begin : g_bad_window
			$error("Code change window too short");
		end
		if (status_pkg::VID_COUNT_WIDTH < 1) begin : g_bad_count
			$error("Window counter too narrow");
		end
	endgenerate

	// Word address match against a register index
	function automatic logic addr_hits(
		input logic [status_pkg::ADDR_WIDTH-1:0] addr,
		input logic [7:0] index
	);
		logic [status_pkg::ADDR_WIDTH-3:0] word;
		word = addr[status_pkg::ADDR_WIDTH-1:2];
		addr_hits = (word == (status_pkg::ADDR_WIDTH-2)'(index));
	endfunction

	// Sticky flag update, set wins over clear
	function automatic logic [7:0] sticky(
		input logic [7:0] flags,
		input logic [7:0] set,
		input logic [7:0] clear_ok,
		input logic clear
	);
		logic [7:0] cleared;
		cleared = clear ? (flags & ~clear_ok) : flags;
		sticky = set | cleared;
	endfunction

	// Stored state
	logic [7:0] status1_reg;
	logic [7:0] status1_next;
	logic [7:0] status2_reg;
	logic [7:0] status2_next;
	logic [7:0] config_reg;
	logic [7:0] config_next;
	logic [15:0] mask_reg;
	logic [15:0] mask_next;
	logic [VID_WIDTH-1:0] vid_snapshot_reg;
	logic [status_pkg::VID_COUNT_WIDTH-1:0] vid_count_reg;
	logic aw_held_reg;
	logic [status_pkg::ADDR_WIDTH-1:0] aw_addr_reg;
	logic w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Handshake terms
	wire aw_take;
	wire w_take;
	wire ar_take;
	wire do_write;
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Write address decode
	wire wr_status1;
	wire wr_status2;
	wire wr_config;
	wire wr_mask;
	wire wr_mapped;
	assign wr_status1 = addr_hits(aw_addr_reg, status_pkg::STATUS1_INDEX);
	assign wr_status2 = addr_hits(aw_addr_reg, status_pkg::STATUS2_INDEX);
	assign wr_config = addr_hits(aw_addr_reg, status_pkg::CONFIG_INDEX);
	assign wr_mask = addr_hits(aw_addr_reg, status_pkg::MASK_INDEX);
	assign wr_mapped = wr_status1 || wr_status2 || wr_config || wr_mask;

	// Read address decode
	wire rd_status1;
	wire rd_status2;
	wire rd_config;
	wire rd_mask;
	wire rd_mapped;
	assign rd_status1 = addr_hits(s_axi_araddr, status_pkg::STATUS1_INDEX);
	assign rd_status2 = addr_hits(s_axi_araddr, status_pkg::STATUS2_INDEX);
	assign rd_config = addr_hits(s_axi_araddr, status_pkg::CONFIG_INDEX);
	assign rd_mask = addr_hits(s_axi_araddr, status_pkg::MASK_INDEX);
	assign rd_mapped = rd_status1 || rd_status2 || rd_config || rd_mask;

	// Clear strobes from a taken read
	wire clear_status1;
	wire clear_status2;
	assign clear_status1 = ar_take && rd_status1;
	assign clear_status2 = ar_take && rd_status2;

	// Configuration fields
	wire vid_select;
	wire timer_mode;
	assign vid_select = config_reg[status_pkg::CFG_VID_SELECT_BIT];
	assign timer_mode = config_reg[status_pkg::CFG_TIMER_MODE_BIT];

	// Code change detection over the sampling window
	wire vid_tick;
	wire [VID_WIDTH-1:0] vid_masked;
	wire vid_differs;
	wire vid_change;
	localparam logic [status_pkg::VID_COUNT_WIDTH-1:0] VID_LAST =
		status_pkg::VID_COUNT_WIDTH'(status_pkg::VID_WINDOW_CYCLES - 1);
	assign vid_tick = (vid_count_reg == VID_LAST);
	assign vid_masked = vid_select ? core_voltage_code :
		{1'b0, core_voltage_code[VID_WIDTH-2:0]};
	assign vid_differs = (vid_masked != vid_snapshot_reg);
	assign vid_change = vid_tick && vid_differs;

	wire [status_pkg::VID_COUNT_WIDTH-1:0] vid_count_next;
	assign vid_count_next = vid_tick ? '0 :
		vid_count_reg + 1'b1;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			vid_count_reg <= '0;
		end else begin
			vid_count_reg <= vid_count_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			vid_snapshot_reg <= '0;
		end else if (vid_tick) begin
			vid_snapshot_reg <= vid_masked;
		end
	end

	// Status one set and hold-off conditions
	logic [7:0] s1_set;
	logic [7:0] s1_active;
	logic [7:0] s1_clear_ok;
	always_comb begin
		s1_set = 8'h00;
		s1_set[status_pkg::S1_SUPPLY_LSB +: 4] = supply_out_of_limit;
		s1_set[status_pkg::S1_TEMP_LSB +: 3] = temp_out_of_limit;
		s1_active = s1_set;
		s1_clear_ok = ~s1_active;
	end

	// Status two per-bit conditions
	wire bit0_set;
	wire bit0_active;
	wire [2:0] cooler_set;
	wire cooler_four_set;
	wire bit5_set;
	logic [7:0] s2_set;
	logic [7:0] s2_active;
	logic [7:0] s2_clear_ok;
	assign bit0_set = vid_select ? vid_change : twelve_volt_out_of_limit;
	assign bit0_active = vid_select ? vid_differs : twelve_volt_out_of_limit;
	assign cooler_set = cooler_slow[2:0] & ~pwm_off;
	assign cooler_four_set = cooler_slow[3] && !pwm_off[2];
	assign bit5_set = timer_mode ? overheat_timer_over : cooler_four_set;
	always_comb begin
		s2_set = 8'h00;
		s2_set[status_pkg::S2_TWELVE_VID_BIT] = bit0_set;
		s2_set[status_pkg::S2_OVERHEAT_BIT] = overheat_limit_hit;
		s2_set[status_pkg::S2_COOLER_LSB +: 3] = cooler_set;
		s2_set[status_pkg::S2_COOLER_FOUR_BIT] = bit5_set;
		s2_set[status_pkg::S2_DIODE_LSB +: 2] = diode_fault;
		s2_active = s2_set;
		s2_active[status_pkg::S2_TWELVE_VID_BIT] = bit0_active;
		s2_active[status_pkg::S2_OVERHEAT_BIT] = !overheat_below_hyst;
		s2_clear_ok = ~s2_active;
	end

	// Stored flag updates
	assign status1_next = sticky(status1_reg, s1_set, s1_clear_ok,
		clear_status1) & 8'h7F;
	assign status2_next = sticky(status2_reg, s2_set, s2_clear_ok,
		clear_status2);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status1_reg <= status_pkg::STATUS1_RESET;
			status2_reg <= status_pkg::STATUS2_RESET;
		end else begin
			status1_reg <= status1_next;
			status2_reg <= status2_next;
		end
	end

	// Visible status one with summary bit
	wire summary;
	logic [7:0] status1_view;
	assign summary = |status2_reg;
	always_comb begin
		status1_view = status1_reg;
		status1_view[status_pkg::S1_SUMMARY_BIT] = summary;
	end

	// Interrupt output from unmasked flags
	wire [15:0] flag_view;
	wire [15:0] pending;
	assign flag_view = {status2_reg, status1_view};
	assign pending = flag_view & mask_reg;
	assign irq = |pending;

	// Write channel capture
	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (aw_take) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else if (w_take) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	// Writable registers with byte lanes
	wire cfg_we;
	wire mask_lo_we;
	wire mask_hi_we;
	assign cfg_we = do_write && wr_config && w_strb_reg[0];
	assign mask_lo_we = do_write && wr_mask && w_strb_reg[0];
	assign mask_hi_we = do_write && wr_mask && w_strb_reg[1];
	assign config_next = cfg_we ? (w_data_reg[7:0] & 8'h03) : config_reg;
	assign mask_next = {mask_hi_we ? w_data_reg[15:8] : mask_reg[15:8],
		mask_lo_we ? w_data_reg[7:0] : mask_reg[7:0]};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			config_reg <= status_pkg::CONFIG_RESET;
			mask_reg <= status_pkg::MASK_RESET;
		end else begin
			config_reg <= config_next;
			mask_reg <= mask_next;
		end
	end

	// Write response
	wire [1:0] wr_resp;
	assign wr_resp = wr_mapped ? status_pkg::RESP_OKAY :
		status_pkg::RESP_SLVERR;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= status_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_resp;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read data selection
	logic [31:0] read_word;
	always_comb begin
		read_word = 32'h00000000;
		if (rd_status1) begin
			read_word[7:0] = status1_view;
		end else if (rd_status2) begin
			read_word[7:0] = status2_reg;
		end else if (rd_config) begin
			read_word[7:0] = config_reg;
		end else if (rd_mask) begin
			read_word[15:0] = mask_reg;
		end
	end

	// Read response, value returned is before the clear
	wire [1:0] rd_resp;
	assign rd_resp = rd_mapped ? status_pkg::RESP_OKAY :
		status_pkg::RESP_SLVERR;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= status_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= read_word;
			rresp_reg <= rd_resp;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule

// ==== tb/status_checker_asserts.sv ====
// Checker of bus timing and flag capture at the block ports
`timescale 1ns/1ns
module status_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [status_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] supply_out_of_limit,
	input wire logic [2:0] temp_out_of_limit,
	input wire logic [3:0] cooler_slow,
	input wire logic [2:0] pwm_off,
	input wire logic [1:0] diode_fault,
	input wire logic irq
);
	logic [6:0] s1_cond_reg;
	logic [5:0] s2_cond_reg;
	logic ok_reg;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire [9:0] idx = s_axi_araddr[11:2];
	wire rd_s1 = ar_hs && idx == 10'h041;
	wire rd_s2 = ar_hs && idx == 10'h042;
	wire rd_bad = ar_hs && !(idx inside {10'h041, 10'h042, 10'h07E, 10'h07F});
	always_ff @(posedge clk) begin
		ok_reg <= resetn;
		s1_cond_reg <= {temp_out_of_limit, supply_out_of_limit};
		s2_cond_reg <= {diode_fault, 1'h0, cooler_slow[2:0] & ~pwm_off};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_read_latency: assert property (ar_hs |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready &&
		!s_axi_wready) else $error("write taken while busy");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	a_unmapped_error: assert property (rd_bad |=> s_axi_rdata == 32'h0 &&
		s_axi_rresp == status_pkg::RESP_SLVERR) else $error("bad read ok");
	a_upper_zero: assert property (s_axi_rvalid |->
		s_axi_rdata[31:16] == 16'h0) else $error("upper bits set");
	a_status1_capture: assert property (rd_s1 && ok_reg |=>
		(s_axi_rdata[6:0] & $past(s1_cond_reg)) == $past(s1_cond_reg))
		else $error("status one flag lost");
	a_status2_capture: assert property (rd_s2 && ok_reg |=>
		(s_axi_rdata[7:2] & $past(s2_cond_reg)) == $past(s2_cond_reg))
		else $error("status two flag lost");
	c_read_one: cover property (rd_s1);
	c_read_two: cover property (rd_s2);
	c_irq: cover property ($rose(irq));
endmodule

// ==== tb/host_model.sv ====
// Host model driving the register bus
`timescale 1ns/1ns
module host_model (
	input wire logic clk,
	output logic [11:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [11:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] v,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while ((s_axi_awvalid && !s_axi_awready) ||
			(s_axi_wvalid && !s_axi_wready));
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		s_axi_araddr <= ~a;
		do @(posedge clk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
endmodule

// ==== tb/monitor_interrupt_status_flags_tb.sv ====
// Self-checking bench for the interrupt status flag block
`timescale 1ns/1ns
module monitor_interrupt_status_flags_tb;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic [17:0] cond = 18'h00000;
	logic overheat_below_hyst = 1'h1;
	logic overheat_timer_over = 1'h0;
	logic [5:0] core_voltage_code = 6'h00;
	wire logic twelve_volt_out_of_limit, overheat_limit_hit, irq;
	wire logic [3:0] supply_out_of_limit, cooler_slow, s_axi_wstrb;
	wire logic [2:0] temp_out_of_limit, pwm_off;
	wire logic [1:0] diode_fault, s_axi_bresp, s_axi_rresp;
	wire logic [11:0] s_axi_awaddr, s_axi_araddr;
	wire logic [31:0] s_axi_wdata, s_axi_rdata;
	wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	wire logic s_axi_rvalid, s_axi_rready;
	logic [31:0] d;
	logic [1:0] r;
	logic [11:0] a;
	int fail_count = 0;
	int total_checks = 0;
	logic [26:0] rows [8] = '{{18'h00005, 1'h0, 8'h05},
		{18'h00050, 1'h0, 8'h50}, {18'h00780, 1'h1, 8'h3C},
		{18'h03F80, 1'h1, 8'h00}, {18'h01F80, 1'h1, 8'h30},
		{18'h0C000, 1'h1, 8'hC0}, {18'h10000, 1'h1, 8'h02},
		{18'h20000, 1'h1, 8'h01}};
	assign {twelve_volt_out_of_limit, overheat_limit_hit, diode_fault,
		pwm_off, cooler_slow, temp_out_of_limit,
		supply_out_of_limit} = cond;
	always #50 clk = ~clk;
	monitor_interrupt_status_flags monitor_interrupt_status_flags_inst (.*);
	host_model host_model_inst (.*);
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk(input logic [11:0] ad, input logic [31:0] e);
		host_model_inst.rd(ad, d, r);
		cmp(d, e);
	endtask
	task automatic pulse(input logic [17:0] v);
		@(posedge clk);
		cond <= v;
		repeat (2) @(posedge clk);
		cond <= 18'h00000;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		fail_count++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'h1;
		chk(12'h104, 32'h0);
		chk(12'h108, 32'h0);
		chk(12'h1FC, 32'h0);
		for (int i = 0; i < 8; i++) begin
			pulse(rows[i][26:9]);
			a = rows[i][8] ? 12'h108 : 12'h104;
			chk(a, {24'h0, rows[i][7:0]});
			chk(a, 32'h0);
		end
		pulse(18'h0C000);
		cmp(irq, 1'h0);
		chk(12'h104, 32'h80);
		chk(12'h104, 32'h80);
		chk(12'h108, 32'hC0);
		chk(12'h104, 32'h0);
		@(posedge clk);
		cond <= 18'h00001;
		chk(12'h104, 32'h1);
		chk(12'h104, 32'h1);
		cond <= 18'h00000;
		chk(12'h104, 32'h1);
		chk(12'h104, 32'h0);
		overheat_below_hyst <= 1'h0;
		pulse(18'h10000);
		chk(12'h108, 32'h2);
		chk(12'h108, 32'h2);
		overheat_below_hyst <= 1'h1;
		chk(12'h108, 32'h2);
		chk(12'h108, 32'h0);
		pulse(18'h00002);
		host_model_inst.wr(12'h104, 32'h0, r);
		cmp(r, status_pkg::RESP_OKAY);
		host_model_inst.wr(12'h108, 32'hFF, r);
		chk(12'h104, 32'h2);
		chk(12'h108, 32'h0);
		host_model_inst.wr(12'h000, 32'h1, r);
		cmp(r, status_pkg::RESP_SLVERR);
		host_model_inst.rd(12'h000, d, r);
		cmp(r, status_pkg::RESP_SLVERR);
		cmp(d, 32'h0);
		host_model_inst.wr(12'h1FC, 32'h100, r);
		host_model_inst.wr(12'h1F8, 32'h1, r);
		core_voltage_code <= 6'h2A;
		repeat (240) @(posedge clk);
		cmp(irq, 1'h1);
		chk(12'h108, 32'h1);
		cmp(irq, 1'h0);
		chk(12'h108, 32'h0);
		host_model_inst.wr(12'h1F8, 32'h2, r);
		overheat_timer_over <= 1'h1;
		chk(12'h108, 32'h20);
		overheat_timer_over <= 1'h0;
		chk(12'h108, 32'h20);
		chk(12'h108, 32'h0);
		pulse(18'h00001);
		resetn <= 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		chk(12'h104, 32'h0);
		chk(12'h1FC, 32'h0);
		chk(12'h1F8, 32'h0);
		cmp(irq, 1'h0);
		final_report();
	end
endmodule
bind monitor_interrupt_status_flags status_checker status_checker_inst (.*);
